// ==== src/tcs_pkg.sv ====
// Purpose: constants for the timer channel status and interrupt block
// Assumes: 32-bit register port, byte addresses, one clock
// Notes:   offsets are word aligned
package tcs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VAL_W  = 16;
    localparam int EVT_N  = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CCB  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CLC  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_EVF  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IES  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IEC  = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IEV  = 8'h2C;

    // status field positions
    localparam int BIT_OVF  = 0;
    localparam int BIT_LOVR = 1;
    localparam int BIT_CMPA = 2;
    localparam int BIT_CMPB = 3;
    localparam int BIT_CMPC = 4;
    localparam int BIT_LDA  = 5;
    localparam int BIT_LDB  = 6;
    localparam int BIT_ETRG = 7;
    localparam int BIT_CLKR = 16;
    localparam int BIT_MIRA = 17;
    localparam int BIT_MIRB = 18;

    // flags that only exist in one mode
    localparam logic [EVT_N-1:0] CAPTURE_ONLY = 8'h62;
    localparam logic [EVT_N-1:0] WAVE_ONLY    = 8'h0C;

    // reset values
    localparam logic [VAL_W-1:0]  CCB_RST = 16'h0000;
    localparam logic [VAL_W-1:0]  CLC_RST = 16'h0000;
    localparam logic [EVT_N-1:0]  IEV_RST = 8'h00;
    localparam logic [EVT_N-1:0]  EVF_RST = 8'h00;
    localparam logic [DATA_W-1:0] RD_RST  = 32'h0000_0000;
endpackage

// ==== src/tcs_channel.sv ====
// Purpose: status, compare b/c and interrupt registers of one timer channel
// Assumes: counter core on the same clock supplies event pulses and values
// Notes:   io line pins are asynchronous and pass four flip-flops
`timescale 1ns/1ps

module tcs_channel
    import tcs_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // register port
    input  wire logic [tcs_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [tcs_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [tcs_pkg::DATA_W-1:0]  reg_rdata,
    // channel core
    input  wire logic                        wave_mode,
    input  wire logic                        clock_running,
    input  wire logic [tcs_pkg::VAL_W-1:0]   cnt_value,
    input  wire logic                        cnt_step,
    input  wire logic                        ovf_evt,
    input  wire logic                        ext_trig_evt,
    input  wire logic [tcs_pkg::VAL_W-1:0]   capture_compare_a,
    input  wire logic                        cca_read,
    input  wire logic                        load_a_evt,
    input  wire logic                        load_b_evt,
    input  wire logic [tcs_pkg::VAL_W-1:0]   cap_value,
    output logic      [tcs_pkg::VAL_W-1:0]   capture_compare_b,
    output logic      [tcs_pkg::VAL_W-1:0]   compare_limit_c,
    // io lines
    input  wire logic                        io_line_a_pin,
    input  wire logic                        io_line_b_pin,
    input  wire logic                        io_line_a_drv,
    input  wire logic                        io_line_b_drv,
    // interrupt
    output logic                             irq
);
    import tcs_pkg::*;

    logic [VAL_W-1:0]  ccb_ff;
    logic [VAL_W-1:0]  clc_ff;
    logic [EVT_N-1:0]  evf_ff;
    logic [EVT_N-1:0]  iev_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              irq_ff;
    logic              a_pend_ff;
    logic              b_pend_ff;
    logic [2:0]        sync_a_ff;
    logic [2:0]        sync_b_ff;
    logic              lvl_a_ff;
    logic              lvl_b_ff;
    logic [EVT_N-1:0]  evt;
    logic [EVT_N-1:0]  evf_vis;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] nxt_rdata;
    logic              evf_rd;
    logic              ccb_rd;
    logic              mir_a;
    logic              mir_b;
    logic              cmp_a;
    logic              cmp_b;
    logic              cmp_c;

    assign evf_rd = reg_rd && (reg_addr == OFS_EVF);
    assign ccb_rd = reg_rd && (reg_addr == OFS_CCB);

    // compare matches on each counter step
    assign cmp_a = cnt_step && (cnt_value == capture_compare_a);
    assign cmp_b = cnt_step && (cnt_value == ccb_ff);
    assign cmp_c = cnt_step && (cnt_value == clc_ff);

    // compare/capture b: capture loads, software writes only in waveform
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ccb_ff <= CCB_RST;
        end else if (!wave_mode && load_b_evt) begin
            ccb_ff <= cap_value;
        end else if (wave_mode && reg_wr && reg_addr == OFS_CCB) begin
            ccb_ff <= reg_wdata[VAL_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clc_ff <= CLC_RST;
        end else if (reg_wr && reg_addr == OFS_CLC) begin
            clc_ff <= reg_wdata[VAL_W-1:0];
        end
    end

    // loaded-but-unread tracking for overrun
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_pend_ff <= 1'b0;
            b_pend_ff <= 1'b0;
        end else begin
            a_pend_ff <= (load_a_evt && !wave_mode) || (a_pend_ff && !cca_read);
            b_pend_ff <= (load_b_evt && !wave_mode) || (b_pend_ff && !ccb_rd);
        end
    end

    // raw event vector, gated by mode
    always_comb begin
        evt           = '0;
        evt[BIT_OVF]  = ovf_evt;
        evt[BIT_LOVR] = !wave_mode && ((load_a_evt && a_pend_ff) || (load_b_evt && b_pend_ff));
        evt[BIT_CMPA] = wave_mode && cmp_a;
        evt[BIT_CMPB] = wave_mode && cmp_b;
        evt[BIT_CMPC] = cmp_c;
        evt[BIT_LDA]  = !wave_mode && load_a_evt;
        evt[BIT_LDB]  = !wave_mode && load_b_evt;
        evt[BIT_ETRG] = ext_trig_evt;
    end

    // sticky flags: an event in the clearing read's cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < EVT_N; gi++) begin : g_flag
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    evf_ff[gi] <= 1'b0;
                end else begin
                    evf_ff[gi] <= evt[gi] || (evf_ff[gi] && !evf_rd);
                end
            end
        end
    endgenerate

    // flags of the other mode read as zero
    assign evf_vis = wave_mode ? (evf_ff & ~CAPTURE_ONLY) : (evf_ff & ~WAVE_ONLY);

    // pin synchronisers, level taken once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a_ff <= 3'h0;
            sync_b_ff <= 3'h0;
            lvl_a_ff  <= 1'b0;
            lvl_b_ff  <= 1'b0;
        end else begin
            sync_a_ff <= {sync_a_ff[1:0], io_line_a_pin};
            sync_b_ff <= {sync_b_ff[1:0], io_line_b_pin};
            if (sync_a_ff[1] == sync_a_ff[2]) begin
                lvl_a_ff <= sync_a_ff[2];
            end
            if (sync_b_ff[1] == sync_b_ff[2]) begin
                lvl_b_ff <= sync_b_ff[2];
            end
        end
    end

    assign mir_a = wave_mode ? io_line_a_drv : lvl_a_ff;
    assign mir_b = wave_mode ? io_line_b_drv : lvl_b_ff;

    always_comb begin
        status_word           = '0;
        status_word[EVT_N-1:0] = evf_vis;
        status_word[BIT_CLKR] = clock_running;
        status_word[BIT_MIRA] = mir_a;
        status_word[BIT_MIRB] = mir_b;
    end

    // interrupt enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            iev_ff <= IEV_RST;
        end else if (reg_wr && reg_addr == OFS_IES) begin
            iev_ff <= iev_ff | reg_wdata[EVT_N-1:0];
        end else if (reg_wr && reg_addr == OFS_IEC) begin
            iev_ff <= iev_ff & ~reg_wdata[EVT_N-1:0];
        end
    end

    // read mux, data one cycle after the strobe
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CCB: nxt_rdata[VAL_W-1:0] = ccb_ff;
                OFS_CLC: nxt_rdata[VAL_W-1:0] = clc_ff;
                OFS_EVF: nxt_rdata = status_word;
                OFS_IEV: nxt_rdata[EVT_N-1:0] = iev_ff;
                default: nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= RD_RST;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(evf_vis & iev_ff);
        end
    end

    assign reg_rdata         = rdata_ff;
    assign capture_compare_b = ccb_ff;
    assign compare_limit_c   = clc_ff;
    assign irq               = irq_ff;

    // checks
    sequence s_evf_read;
        reg_rd && (reg_addr == OFS_EVF);
    endsequence

    sequence s_quiet_ovf;
        !ovf_evt;
    endsequence

    sequence s_ccb_write;
        reg_wr && (reg_addr == OFS_CCB);
    endsequence

    sequence s_load_b_capt;
        !wave_mode && load_b_evt;
    endsequence

    chk_ovf_sets: assert property (@(posedge clk) disable iff (rst)
        ovf_evt |=> evf_ff[BIT_OVF])
        else $error("overflow did not set flag");

    chk_read_clears_c: assert property (@(posedge clk) disable iff (rst)
        (s_evf_read and !cmp_c) |=> !evf_ff[BIT_CMPC])
        else $error("status read did not clear compare c");

    chk_trig_survives_read: assert property (@(posedge clk) disable iff (rst)
        (s_evf_read and ext_trig_evt) |=> evf_ff[BIT_ETRG] ##1 (evf_ff[BIT_ETRG] || $past(evf_rd)))
        else $error("trigger lost on read");

    chk_ovf_read_zero: assert property (@(posedge clk) disable iff (rst)
        (s_evf_read ##1 s_evf_read and s_quiet_ovf) |=> !reg_rdata[BIT_OVF])
        else $error("overflow flag still read after clear");

    chk_overrun_capt: assert property (@(posedge clk) disable iff (rst)
        (!wave_mode && load_a_evt && a_pend_ff) |=> evf_ff[BIT_LOVR])
        else $error("overrun not flagged");

    chk_wave_zero: assert property (@(posedge clk) disable iff (rst)
        (s_evf_read and wave_mode) |=> (reg_rdata[BIT_LOVR] == 1'b0 && reg_rdata[BIT_LDA] == 1'b0
                                         && reg_rdata[BIT_LDB] == 1'b0))
        else $error("capture flags visible in waveform mode");

    chk_capt_zero: assert property (@(posedge clk) disable iff (rst)
        (s_evf_read and !wave_mode) |=> (reg_rdata[BIT_CMPA] == 1'b0 && reg_rdata[BIT_CMPB] == 1'b0))
        else $error("compare flags visible in capture mode");

    chk_ccb_guard: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == OFS_CCB && !wave_mode && !load_b_evt) |=> $stable(ccb_ff))
        else $error("compare b written in capture mode");

    chk_clc_write: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == OFS_CLC) |=> clc_ff == $past(reg_wdata[VAL_W-1:0]))
        else $error("compare c write lost");

    chk_enable_set: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == OFS_IES && reg_wdata[BIT_CMPC]) |=> iev_ff[BIT_CMPC])
        else $error("enable write had no effect");

    chk_disable_clr: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == OFS_IEC) |=> ((iev_ff & $past(reg_wdata[EVT_N-1:0])) == '0)
                                            && ((iev_ff | $past(reg_wdata[EVT_N-1:0])) == ($past(iev_ff) | $past(reg_wdata[EVT_N-1:0]))))
        else $error("disable write wrong");

    chk_mask_read: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_addr == OFS_IEV) |=> reg_rdata == {24'h000000, $past(iev_ff)})
        else $error("mask view wrong");

    chk_irq_follows: assert property (@(posedge clk) disable iff (rst)
        (|(evf_vis & iev_ff)) |=> irq)
        else $error("interrupt not raised");

    chk_clk_status: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_addr == OFS_EVF) |=> reg_rdata[BIT_CLKR] == $past(clock_running))
        else $error("clock status wrong");

    chk_mirror_a: assert property (@(posedge clk) disable iff (rst)
        (!wave_mode && io_line_a_pin)[*5] |-> status_word[BIT_MIRA])
        else $error("line a mirror wrong");

    chk_mirror_b: assert property (@(posedge clk) disable iff (rst)
        (s_evf_read and wave_mode) |=> reg_rdata[BIT_MIRB] == $past(io_line_b_drv))
        else $error("line b mirror wrong");

    chk_mirror_b_capt: assert property (@(posedge clk) disable iff (rst)
        (!wave_mode && io_line_b_pin)[*5] |-> status_word[BIT_MIRB])
        else $error("line b pin mirror wrong");

    chk_mirror_a_wave: assert property (@(posedge clk) disable iff (rst)
        (s_evf_read and wave_mode) |=> reg_rdata[BIT_MIRA] == $past(io_line_a_drv))
        else $error("line a driven mirror wrong");

    // capture load of b wins over a software write
    chk_ccb_capture: assert property (@(posedge clk) disable iff (rst)
        s_load_b_capt |=> ccb_ff == $past(cap_value))
        else $error("compare b capture lost");

    chk_ccb_wave_write: assert property (@(posedge clk) disable iff (rst)
        (s_ccb_write and wave_mode) |=> ccb_ff == $past(reg_wdata[VAL_W-1:0]))
        else $error("compare b write lost in waveform mode");

    chk_overrun_b: assert property (@(posedge clk) disable iff (rst)
        (s_load_b_capt and b_pend_ff) |=> evf_ff[BIT_LOVR])
        else $error("overrun on b not flagged");

    chk_pend_a_clear: assert property (@(posedge clk) disable iff (rst)
        (cca_read && !load_a_evt) |=> !a_pend_ff)
        else $error("register a read did not clear pending load");

    chk_cmpa_wave: assert property (@(posedge clk) disable iff (rst)
        (wave_mode && cmp_a) |=> evf_ff[BIT_CMPA])
        else $error("compare a match not flagged");

    chk_cmpc_sets: assert property (@(posedge clk) disable iff (rst)
        cmp_c |=> evf_ff[BIT_CMPC])
        else $error("compare c match not flagged");

    chk_load_a_capt: assert property (@(posedge clk) disable iff (rst)
        (!wave_mode && load_a_evt) |=> evf_ff[BIT_LDA])
        else $error("load a not flagged");

    chk_irq_drops: assert property (@(posedge clk) disable iff (rst)
        !(|(evf_vis & iev_ff)) |=> !irq)
        else $error("interrupt high with no enabled flag");
endmodule

// ==== testbench/timer_channel_status_irq_tb.sv ====
// Purpose: self-checking bench for the timer channel status and interrupt block
// Assumes: bench plays the counter core and the register port master
// Notes:   register a read pulse is raised only in the overrun scenario
`timescale 1ns/1ps
module timer_channel_status_irq_tb;
    import tcs_pkg::*;
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              wave_mode;
    logic              clock_running;
    logic [VAL_W-1:0]  cnt_value;
    logic              cnt_step;
    logic              ovf_evt;
    logic              ext_trig_evt;
    logic [VAL_W-1:0]  capture_compare_a;
    logic              cca_read;
    logic              load_a_evt;
    logic              load_b_evt;
    logic [VAL_W-1:0]  cap_value;
    logic [VAL_W-1:0]  capture_compare_b;
    logic [VAL_W-1:0]  compare_limit_c;
    logic              pin_a;
    logic              pin_b;
    logic              drv_a;
    logic              drv_b;
    logic              irq;
    int                errors;
    int                comparisons;

    tcs_channel tcs_channel_inst (
        .clk               (clk),
        .rst               (rst),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata         (reg_rdata),
        .wave_mode         (wave_mode),
        .clock_running     (clock_running),
        .cnt_value         (cnt_value),
        .cnt_step          (cnt_step),
        .ovf_evt           (ovf_evt),
        .ext_trig_evt      (ext_trig_evt),
        .capture_compare_a (capture_compare_a),
        .cca_read          (cca_read),
        .load_a_evt        (load_a_evt),
        .load_b_evt        (load_b_evt),
        .cap_value         (cap_value),
        .capture_compare_b (capture_compare_b),
        .compare_limit_c   (compare_limit_c),
        .io_line_a_pin     (pin_a),
        .io_line_b_pin     (pin_b),
        .io_line_a_drv     (drv_a),
        .io_line_b_drv     (drv_b),
        .irq               (irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask

    // two reads back to back, each result taken in its own cycle
    task automatic rd_pair(input string what, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] exp1, input logic [DATA_W-1:0] exp2);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        #1;
        chk(what, reg_rdata, exp1);
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(what, reg_rdata, exp2);
    endtask

    // one-cycle pulses: overflow, trigger, load a, load b, count step
    task automatic evt(input logic [4:0] e);
        @(posedge clk);
        {ovf_evt, ext_trig_evt, load_a_evt, load_b_evt, cnt_step} <= e;
        @(posedge clk);
        {ovf_evt, ext_trig_evt, load_a_evt, load_b_evt, cnt_step} <= 5'h00;
    endtask

    task automatic t_reset;
        rd_chk("b reset", OFS_CCB, 32'h0000_0000);
        rd_chk("c reset", OFS_CLC, 32'h0000_0000);
        rd_chk("status reset", OFS_EVF, 32'h0000_0000);
        rd_chk("mask reset", OFS_IEV, 32'h0000_0000);
        rd_chk("enable set reads zero", OFS_IES, 32'h0000_0000);
        rd_chk("enable clear reads zero", OFS_IEC, 32'h0000_0000);
        rd_chk("unmapped", 8'h00, 32'h0000_0000);
    endtask

    task automatic t_regs;
        wr(OFS_CLC, 32'hFFFF_A5C3);
        rd_chk("c capture", OFS_CLC, 32'h0000_A5C3);
        wr(OFS_CCB, 32'h0000_1234);
        rd_chk("b write refused", OFS_CCB, 32'h0000_0000);
        cap_value <= 16'hBEEF;
        evt(5'b00010);
        rd_chk("b captured", OFS_CCB, 32'h0000_BEEF);
        chk("b port", {16'h0000, capture_compare_b}, 32'h0000_BEEF);
        rd_chk("load b flag", OFS_EVF, 32'h0000_0040);
        @(posedge clk);
        wave_mode <= 1'b1;
        wr(OFS_CLC, 32'h0000_3C5A);
        rd_chk("c wave", OFS_CLC, 32'h0000_3C5A);
        chk("c port", {16'h0000, compare_limit_c}, 32'h0000_3C5A);
        @(posedge clk);
        wave_mode <= 1'b0;
    endtask

    task automatic t_capture;
        @(posedge clk);
        clock_running     <= 1'b1;
        cnt_value         <= 16'h3C5A;
        capture_compare_a <= 16'h3C5A;
        evt(5'b11111);
        rd_chk("capture flags", OFS_EVF, 32'h0001_00F1);
        rd_chk("flags cleared", OFS_EVF, 32'h0001_0000);
        evt(5'b00010);
        rd_chk("overrun", OFS_EVF, 32'h0001_0042);
        rd_chk("b read", OFS_CCB, 32'h0000_BEEF);
        evt(5'b00010);
        rd_chk("no overrun after read", OFS_EVF, 32'h0001_0040);
        evt(5'b00100);
        rd_chk("overrun a", OFS_EVF, 32'h0001_0022);
        @(posedge clk);
        cca_read <= 1'b1;
        @(posedge clk);
        cca_read <= 1'b0;
        evt(5'b00100);
        rd_chk("no overrun after a read", OFS_EVF, 32'h0001_0020);
        @(posedge clk);
        clock_running <= 1'b0;
        pin_a         <= 1'b1;
        pin_b         <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk("pin mirror", OFS_EVF, 32'h0006_0000);
        pin_a <= 1'b0;
        repeat (6) @(posedge clk);
        rd_chk("pin a low", OFS_EVF, 32'h0004_0000);
    endtask

    task automatic t_irq;
        wr(OFS_IES, 32'h0000_0011);
        rd_chk("mask set", OFS_IEV, 32'h0000_0011);
        wr(OFS_IEC, 32'h0000_0001);
        rd_chk("mask clear", OFS_IEV, 32'h0000_0010);
        wr(OFS_IES, 32'hFFFF_FF00);
        wr(OFS_IEV, 32'h0000_00FF);
        wr(OFS_EVF, 32'h0000_00FF);
        rd_chk("zero bits no effect", OFS_IEV, 32'h0000_0010);
        evt(5'b10000);
        repeat (3) @(posedge clk);
        #1;
        chk("irq masked", {31'h0, irq}, 32'h0000_0000);
        evt(5'b00001);
        repeat (3) @(posedge clk);
        #1;
        chk("irq raised", {31'h0, irq}, 32'h0000_0001);
        rd_chk("irq status", OFS_EVF, 32'h0004_0011);
        repeat (3) @(posedge clk);
        #1;
        chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
        evt(5'b10000);
        rd_pair("status twice", OFS_EVF, 32'h0004_0001, 32'h0004_0000);
    endtask

    task automatic t_wave;
        @(posedge clk);
        wave_mode         <= 1'b1;
        drv_a             <= 1'b1;
        capture_compare_a <= 16'h0123;
        cnt_value         <= 16'h0123;
        wr(OFS_CCB, 32'hFFFF_0456);
        rd_chk("b wave write", OFS_CCB, 32'h0000_0456);
        evt(5'b00001);
        cnt_value <= 16'h0456;
        evt(5'b00001);
        repeat (4) @(posedge clk);
        rd_chk("compare a b", OFS_EVF, 32'h0002_000C);
        cap_value <= 16'h7777;
        drv_b     <= 1'b1;
        evt(5'b00010);
        repeat (4) @(posedge clk);
        rd_chk("b kept in wave", OFS_CCB, 32'h0000_0456);
        rd_chk("load flags hidden", OFS_EVF, 32'h0006_0000);
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // run takes well under a thousand cycles
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end

    initial begin
        errors            = 0;
        comparisons       = 0;
        rst               = 1'b1;
        reg_addr          = 8'h00;
        reg_wdata         = 32'h0000_0000;
        reg_wr            = 1'b0;
        reg_rd            = 1'b0;
        wave_mode         = 1'b0;
        clock_running     = 1'b0;
        cnt_value         = 16'h0000;
        cnt_step          = 1'b0;
        ovf_evt           = 1'b0;
        ext_trig_evt      = 1'b0;
        capture_compare_a = 16'h0000;
        cca_read          = 1'b0;
        load_a_evt        = 1'b0;
        load_b_evt        = 1'b0;
        cap_value         = 16'h0000;
        pin_a             = 1'b0;
        pin_b             = 1'b0;
        drv_a             = 1'b0;
        drv_b             = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_capture();
        t_irq();
        t_wave();
        tally_and_finish();
    end
endmodule
